//--- common/ipr_pkg.sv
// Shared constants and types for the interrupt priority recognition block.
package ipr_pkg;

    // ----------------------------------------------------------------
    // Register map, byte offsets on the bus.
    // ----------------------------------------------------------------
    localparam logic [4:0] OFF_CODES      = 5'h00;
    localparam logic [4:0] OFF_STATUS     = 5'h04;
    localparam logic [4:0] OFF_IRQ_STAT   = 5'h08;
    localparam logic [4:0] OFF_IRQ_MASK   = 5'h0c;
    localparam logic [4:0] OFF_PIN_ASSIGN = 5'h10;
    localparam logic [4:0] OFF_ARB        = 5'h14;
    localparam logic [4:0] OFF_RETURN     = 5'h18;
    localparam logic [4:0] OFF_VECTOR     = 5'h1c;

    // ----------------------------------------------------------------
    // Fields and reset values.
    // ----------------------------------------------------------------
    localparam int         MASK_LSB    = 5;
    localparam logic [7:0] CODES_RESET = 8'he0;
    localparam logic [3:0] ARB_RESET   = 4'hf;
    localparam logic [2:0] NMI_LEVEL   = 3'h7;
    localparam int         EV_ACCEPT   = 0;
    localparam int         EV_VECTOR   = 1;
    localparam int         EV_NMI      = 2;
    localparam int         EV_STACK    = 3;
    localparam int         EV_W        = 4;
    localparam int         STK_DEPTH   = 8;

    // ----------------------------------------------------------------
    // Types.
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACK  = 3'b010,
        ST_POP  = 3'b100
    } ipr_state_type;

    typedef struct packed {
        logic       active;
        logic [2:0] level;
    } ipr_ack_type;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [4:0] addr;
    } ipr_bus_phase_type;

endpackage : ipr_pkg

//--- core/ipr_core.sv
// Interrupt priority recognition with acknowledge cycle and register bus.
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module ipr_core #(
    parameter int DEPTH = ipr_pkg::STK_DEPTH
) (
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic                ce,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic      [31:0]         hrdata,
    output logic                     hresp,
    input  wire logic [7:1]          irq_pin_n,
    input  wire logic                strap_data9,
    input  wire logic [7:0]          vec_data,
    input  wire logic                size_acknowledge_n,
    input  wire logic                autovector_termination_n,
    output ipr_pkg::ipr_ack_type     interrupt_ack_cycle,
    output logic                     irq_out
);

    localparam int AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int SP_W = $clog2(DEPTH + 1);

    // ----------------------------------------------------------------
    // Declarations.
    // ----------------------------------------------------------------
    ipr_pkg::ipr_bus_phase_type ph;
    ipr_pkg::ipr_state_type     state;
    logic [7:1]                 pin_meta;
    logic [7:1]                 pin_sync;
    logic [7:1]                 pin_assign;
    logic [7:1]                 req;
    logic                       nmi_prev;
    logic                       nmi_pending;
    logic                       rst_q;
    logic [7:0]                 condition_code_reg;
    logic [3:0]                 module_arbitration_number;
    logic [ipr_pkg::EV_W-1:0]   irq_stat;
    logic [ipr_pkg::EV_W-1:0]   irq_mask;
    logic [ipr_pkg::EV_W-1:0]   ev;
    logic [8:0]                 vec_offset;
    logic [SP_W-1:0]            sp;
    logic [7:0]                 stk_rdata;
    logic [2:0]                 priority_mask;
    logic [2:0]                 cand_lvl;
    logic                       wr_fire;
    logic                       codes_wr;
    logic                       ret_cmd;
    logic                       stack_full;
    logic                       accept;
    logic                       pop_start;
    logic                       term_size;
    logic                       term_auto;
    logic [31:0]                rd_mux;

    // Highest asserted level among one to six, zero when none.
    function automatic logic [2:0] highest(input logic [6:1] r);
        logic [2:0] lvl;
        lvl = 3'h0;
        for (int i = 1; i <= 6; i++)
        begin
            if (r[i])
            begin
                lvl = 3'(i);
            end
        end
        return lvl;
    endfunction : highest

    // ----------------------------------------------------------------
    // Pin synchronisers and request qualification.
    // ----------------------------------------------------------------
    // Two flops; only the second one is ever looked at.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_meta <= 7'h7f;
            pin_sync <= 7'h7f;
        end
        else if (ce)
        begin
            pin_meta <= irq_pin_n;
            pin_sync <= pin_meta;
        end
    end

    // Low pin level means a request, if the pin has its interrupt use.
    assign req = ~pin_sync & pin_assign;

    // Pin function comes from the strap at release, then from software.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rst_q      <= 1'b1;
            pin_assign <= 7'h00;
        end
        else if (ce)
        begin
            rst_q <= 1'b0;
            if (rst_q)
            begin
                pin_assign <= {7{strap_data9}};
            end
            else if (wr_fire && ph.addr == ipr_pkg::OFF_PIN_ASSIGN)
            begin
                pin_assign <= hwdata[7:1];
            end
        end
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY.
    // ----------------------------------------------------------------
    // Address phase is latched; the write happens in the data phase.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ph        <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end
        else if (ce)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready)
            begin
                ph.valid <= hsel & htrans[1];
                ph.write <= hwrite;
                ph.addr  <= haddr[4:0];
                if (hsel && htrans[1] && !hwrite)
                begin
                    hrdata <= rd_mux;
                end
            end
        end
    end

    assign wr_fire   = ph.valid & ph.write;
    assign codes_wr  = wr_fire && ph.addr == ipr_pkg::OFF_CODES;
    assign ret_cmd   = wr_fire && ph.addr == ipr_pkg::OFF_RETURN
                       && hwdata[0];
    assign term_size = state == ipr_pkg::ST_ACK && !size_acknowledge_n;
    assign term_auto = state == ipr_pkg::ST_ACK && size_acknowledge_n
                       && !autovector_termination_n;

    // Read mux; unmapped words read as zero.
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[4:0])
            ipr_pkg::OFF_CODES:      rd_mux[7:0] = condition_code_reg;
            ipr_pkg::OFF_STATUS:     rd_mux = {16'h0000, 8'(sp),
                                        1'b0, state, nmi_pending,
                                        interrupt_ack_cycle.level};
            ipr_pkg::OFF_IRQ_STAT:   rd_mux[ipr_pkg::EV_W-1:0] = irq_stat;
            ipr_pkg::OFF_IRQ_MASK:   rd_mux[ipr_pkg::EV_W-1:0] = irq_mask;
            ipr_pkg::OFF_PIN_ASSIGN: rd_mux[7:1] = pin_assign;
            ipr_pkg::OFF_ARB:   rd_mux[3:0] = module_arbitration_number;
            ipr_pkg::OFF_VECTOR:     rd_mux[8:0] = vec_offset;
            default:                 rd_mux = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // Recognition.
    // ----------------------------------------------------------------
    assign priority_mask = condition_code_reg[ipr_pkg::MASK_LSB +: 3];
    assign stack_full    = sp == SP_W'(DEPTH);
    assign cand_lvl      = nmi_pending ? ipr_pkg::NMI_LEVEL
                                       : highest(req[6:1]);

    // A return or a mask write in the same cycle goes first, so the
    // comparison always sees the mask that software meant.
    assign accept = ce && state == ipr_pkg::ST_IDLE && !codes_wr
                    && !ret_cmd && !stack_full
                    && module_arbitration_number != 4'h0
                    && (nmi_pending
                        || cand_lvl > priority_mask);
    assign pop_start = ce && state == ipr_pkg::ST_IDLE && ret_cmd
                       && sp != '0;

    // Level seven latches a pending request; any setter beats the clear.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            nmi_prev    <= 1'b0;
            nmi_pending <= 1'b0;
        end
        else if (ce)
        begin
            nmi_prev <= req[7];
            if ((req[7] && !nmi_prev)
                || (ret_cmd && req[7])
                || (codes_wr && req[7]))
            begin
                nmi_pending <= 1'b1;
            end
            else if (accept)
            begin
                nmi_pending <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer, condition codes and stack pointer.
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state               <= ipr_pkg::ST_IDLE;
            condition_code_reg  <= ipr_pkg::CODES_RESET;
            sp                  <= '0;
            interrupt_ack_cycle <= '0;
            vec_offset          <= 9'h000;
        end
        else if (ce)
        begin
            unique case (state)
                ipr_pkg::ST_IDLE:
                begin
                    if (accept)
                    begin
                        sp <= sp + SP_W'(1);
                        condition_code_reg[ipr_pkg::MASK_LSB +: 3]
                            <= cand_lvl;
                        interrupt_ack_cycle.active <= 1'b1;
                        interrupt_ack_cycle.level  <= cand_lvl;
                        state <= ipr_pkg::ST_ACK;
                    end
                    else if (pop_start)
                    begin
                        sp    <= sp - SP_W'(1);
                        state <= ipr_pkg::ST_POP;
                    end
                    else if (codes_wr)
                    begin
                        condition_code_reg <= hwdata[7:0];
                    end
                end
                ipr_pkg::ST_ACK:
                begin
                    // The cycle stays open until the far end terminates.
                    if (term_size)
                    begin
                        vec_offset <= {vec_data, 1'b0};
                        interrupt_ack_cycle.active <= 1'b0;
                        state <= ipr_pkg::ST_IDLE;
                    end
                    else if (term_auto)
                    begin
                        vec_offset <= {5'h00,
                            interrupt_ack_cycle.level, 1'b0};
                        interrupt_ack_cycle.active <= 1'b0;
                        state <= ipr_pkg::ST_IDLE;
                    end
                end
                ipr_pkg::ST_POP:
                begin
                    condition_code_reg <= stk_rdata;
                    state <= ipr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Condition codes are pushed before the mask is overwritten.
    ipr_stack_mem #(
        .WIDTH (8),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_stack (
        .sys_clk (sys_clk),
        .ce      (ce),
        .wr_en   (accept),
        .wr_addr (AW'(sp)),
        .wr_data (condition_code_reg),
        .rd_en   (pop_start),
        .rd_addr (AW'(sp - SP_W'(1))),
        .rd_data (stk_rdata)
    );

    // ----------------------------------------------------------------
    // Configuration, event status and interrupt output.
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            module_arbitration_number <= ipr_pkg::ARB_RESET;
            irq_mask                  <= '0;
        end
        else if (ce && wr_fire)
        begin
            if (ph.addr == ipr_pkg::OFF_ARB)
            begin
                module_arbitration_number <= hwdata[3:0];
            end
            if (ph.addr == ipr_pkg::OFF_IRQ_MASK)
            begin
                irq_mask <= hwdata[ipr_pkg::EV_W-1:0];
            end
        end
    end

    always_comb
    begin
        ev = '0;
        ev[ipr_pkg::EV_ACCEPT] = accept;
        ev[ipr_pkg::EV_VECTOR] = ce && (term_size || term_auto);
        ev[ipr_pkg::EV_NMI]    = accept && nmi_pending;
        ev[ipr_pkg::EV_STACK]  = ce && state == ipr_pkg::ST_IDLE
                                 && (stack_full && cand_lvl != 3'h0
                                     || ret_cmd && sp == '0);
    end

    // Write one to clear; a new event in the same cycle wins.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irq_stat <= '0;
            irq_out  <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_fire && ph.addr == ipr_pkg::OFF_IRQ_STAT)
            begin
                irq_stat <= (irq_stat & ~hwdata[ipr_pkg::EV_W-1:0]) | ev;
            end
            else
            begin
                irq_stat <= irq_stat | ev;
            end
            irq_out <= |(irq_stat & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    property p_req_level;
        @(posedge sys_clk) disable iff (rst)
        accept && !nmi_pending |-> req[cand_lvl];
    endproperty
    a_req_level: assert property (p_req_level)
        else $error("accepted level is not asserted");

    property p_above_mask;
        @(posedge sys_clk) disable iff (rst)
        accept && !nmi_pending |-> cand_lvl > priority_mask;
    endproperty
    a_above_mask: assert property (p_above_mask)
        else $error("accepted request not above mask");

    property p_mask_raise;
        @(posedge sys_clk) disable iff (rst)
        accept |=> priority_mask == $past(cand_lvl)
                   && interrupt_ack_cycle.active
                   && sp == $past(sp) + SP_W'(1);
    endproperty
    a_mask_raise: assert property (p_mask_raise)
        else $error("mask or stack not updated on accept");

    property p_pop_restore;
        @(posedge sys_clk) disable iff (rst)
        pop_start ##1 ce |=> condition_code_reg == $past(stk_rdata);
    endproperty
    a_pop_restore: assert property (p_pop_restore)
        else $error("return did not restore condition codes");

    property p_nmi_edge;
        @(posedge sys_clk) disable iff (rst)
        ce && req[7] && !nmi_prev |=> nmi_pending;
    endproperty
    a_nmi_edge: assert property (p_nmi_edge)
        else $error("level seven edge not latched");

    property p_nmi_ret;
        @(posedge sys_clk) disable iff (rst)
        ce && ret_cmd && req[7] |=> nmi_pending;
    endproperty
    a_nmi_ret: assert property (p_nmi_ret)
        else $error("level seven held at return not latched");

    property p_nmi_wr;
        @(posedge sys_clk) disable iff (rst)
        ce && codes_wr && req[7] |=> nmi_pending;
    endproperty
    a_nmi_wr: assert property (p_nmi_wr)
        else $error("mask write with level seven not latched");

    property p_arb_zero;
        @(posedge sys_clk) disable iff (rst)
        module_arbitration_number == 4'h0 |-> !accept;
    endproperty
    a_arb_zero: assert property (p_arb_zero)
        else $error("accept with arbitration number zero");

    property p_vec_size;
        @(posedge sys_clk) disable iff (rst)
        ce && term_size |=> vec_offset == {$past(vec_data), 1'b0}
                            && !interrupt_ack_cycle.active;
    endproperty
    a_vec_size: assert property (p_vec_size)
        else $error("supplied vector offset wrong");

    property p_vec_auto;
        @(posedge sys_clk) disable iff (rst)
        ce && term_auto |=> vec_offset[3:1]
                            == $past(interrupt_ack_cycle.level);
    endproperty
    a_vec_auto: assert property (p_vec_auto)
        else $error("autovector offset wrong");

endmodule : ipr_core

//--- core/ipr_stack_mem.sv
// Small stack memory for saved condition codes, registered read data.
`timescale 1ns/1ps
module ipr_stack_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic             sys_clk,
    input  wire logic             ce,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_en,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Write port; the array has no reset since only pushed words are read.
    always_ff @(posedge sys_clk)
    begin
        if (ce && wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read port; data appear one enabled edge after the request.
    always_ff @(posedge sys_clk)
    begin
        if (ce && rd_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : ipr_stack_mem

//--- verif/ipr_requester.sv
// Behavioural model of an interrupting peripheral at the acknowledge side.
`timescale 1ns/1ps
module ipr_requester (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic [7:1]           req,
    input  wire logic                 use_auto,
    input  wire logic                 slow,
    input  wire logic [7:0]           vec,
    input  wire ipr_pkg::ipr_ack_type ack,
    output logic      [7:1]           irq_pin_n,
    output logic      [7:0]           vec_data,
    output logic                      size_acknowledge_n,
    output logic                      autovector_termination_n
);
    logic [3:0] wait_cnt;
    logic       term;

    // Pins follow the bench's requests, which decide when a request drops.
    assign irq_pin_n = ~req;

    // ------------------------------------------------------------------
    // Acknowledge termination
    // ------------------------------------------------------------------
    // One strobe cycle per acknowledge, after a short or long delay.
    // The data bus churns outside the strobe so stale vectors never match.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            term                     <= 1'b0;
            wait_cnt                 <= 4'h0;
            vec_data                 <= 8'h00;
            size_acknowledge_n       <= 1'b1;
            autovector_termination_n <= 1'b1;
        end
        else if (term)
        begin
            term                     <= 1'b0;
            wait_cnt                 <= 4'h0;
            vec_data                 <= ~vec;
            size_acknowledge_n       <= 1'b1;
            autovector_termination_n <= 1'b1;
        end
        else if (ack.active && wait_cnt == (slow ? 4'h5 : 4'h0))
        begin
            term                     <= 1'b1;
            vec_data                 <= vec;
            size_acknowledge_n       <= use_auto;
            autovector_termination_n <= ~use_auto;
        end
        else
        begin
            wait_cnt <= ack.active ? wait_cnt + 4'h1 : 4'h0;
            vec_data <= vec_data + 8'h5b;
        end
    end
endmodule : ipr_requester

//--- verif/test_interrupt_priority_recognition.sv
// Self-checking bench for the interrupt priority recognition block.
`timescale 1ns/1ps
module test_interrupt_priority_recognition;
    logic                 sys_clk = 1'b0;
    logic                 rst     = 1'b1;
    logic                 hsel    = 1'b0;
    logic [31:0]          haddr   = 32'h0;
    logic [1:0]           htrans  = 2'h0;
    logic                 hwrite  = 1'b0;
    logic [31:0]          hwdata  = 32'h0;
    logic [7:1]           req     = 7'h0;
    logic                 use_auto = 1'b0;
    logic                 ce      = 1'b1;
    logic                 strap   = 1'b1;
    logic [2:0]           hsize   = 3'h2;
    logic                 slow    = 1'b0;
    logic [7:0]           vec     = 8'h0;
    logic                 rd_pend = 1'b0;
    logic                 ack_prev = 1'b0;
    logic [7:0]           v;
    logic [2:0]           l;
    wire                  hreadyout;
    wire                  hresp;
    wire  [31:0]          hrdata;
    wire  [7:1]           irq_pin_n;
    wire  [7:0]           vec_data;
    wire                  size_n;
    wire                  auto_n;
    wire                  irq_out;
    ipr_pkg::ipr_ack_type ack;
    int                   n_fail = 0;
    int                   tests_run = 0;
    int                   cycles = 0;
    int                   seed = 32'ha952;
    logic [2:0]           exp_ack[$];
    logic [32:0]          exp_rd[$];

    always #10 sys_clk = ~sys_clk;

    ipr_core i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .irq_pin_n(irq_pin_n),
        .strap_data9(strap), .vec_data(vec_data),
        .size_acknowledge_n(size_n), .autovector_termination_n(auto_n),
        .interrupt_ack_cycle(ack), .irq_out(irq_out));

    ipr_requester i_req (.sys_clk(sys_clk), .rst(rst), .req(req),
        .use_auto(use_auto), .slow(slow), .vec(vec), .ack(ack),
        .irq_pin_n(irq_pin_n), .vec_data(vec_data),
        .size_acknowledge_n(size_n), .autovector_termination_n(auto_n));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [32:0] e, input logic [32:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk

    task automatic bus(input logic [4:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= {27'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel    <= 1'b0;
        htrans  <= 2'h0;
        hwdata  <= d;
        rd_pend <= ~w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd_pend <= 1'b0;
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_rd.push_back({1'b0, e});
        bus(a, 1'b0, 32'h0);
    endtask : rd

    // Waits for an acknowledge to open and close, with a bounded wait.
    task automatic ackw();
        int k;
        k = 0;
        while (ack.active !== 1'b1 && k < 60)
        begin
            @(posedge sys_clk);
            k++;
        end
        while (ack.active === 1'b1 && k < 120)
        begin
            @(posedge sys_clk);
            k++;
        end
        repeat (2) @(posedge sys_clk);
    endtask : ackw

    // The pop takes two cycles after the write lands, so wait them out.
    task automatic ret();
        bus(ipr_pkg::OFF_RETURN, 1'b1, 32'h1);
        repeat (3) @(posedge sys_clk);
    endtask : ret

    task automatic summarize();
        if (exp_ack.size() != 0 || exp_rd.size() != 0)
            n_fail++;
        if (n_fail == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // Timeout: a hang counts as a mismatch and still reaches the verdict.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            n_fail++;
            summarize();
        end
    end

    // Monitor: any acknowledge start or read data phase takes the oldest
    // note; an acknowledge nobody expected compares against level zero.
    always @(posedge sys_clk)
    begin
        if (ack_prev === 1'b0 && ack.active === 1'b1)
            chk({30'h0, exp_ack.size() ? exp_ack.pop_front() : 3'h0},
                {30'h0, ack.level});
        ack_prev = ack.active;
        if (rd_pend === 1'b1)
            chk(exp_rd.pop_front(), {hresp, hrdata});
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rd(ipr_pkg::OFF_CODES, 32'he0);
        rd(ipr_pkg::OFF_ARB, 32'hf);
        rd(ipr_pkg::OFF_PIN_ASSIGN, 32'hfe);
        bus(ipr_pkg::OFF_IRQ_MASK, 1'b1, 32'h5);
        for (int i = 1; i < 7; i++)
        begin
            l = i[2:0];
            use_auto <= l[0];
            slow <= l[1];
            v = 8'($random(seed));
            vec <= v;
            bus(ipr_pkg::OFF_CODES, 1'b1, {24'h0, l, 5'h0});
            req <= 7'h1 << (i - 1);
            repeat (10) @(posedge sys_clk);
            exp_ack.push_back(l);
            bus(ipr_pkg::OFF_CODES, 1'b1, {24'h0, l - 3'h1, 5'h0});
            ackw();
            rd(ipr_pkg::OFF_VECTOR, l[0] ? {28'h0, l, 1'b0}
                                        : {23'h0, v, 1'b0});
            rd(ipr_pkg::OFF_CODES, {24'h0, l, 5'h0});
            req <= 7'h0;
            ret();
            rd(ipr_pkg::OFF_CODES, {24'h0, l - 3'h1, 5'h0});
        end
        chk(33'h1, {32'h0, irq_out});
        bus(ipr_pkg::OFF_IRQ_MASK, 1'b1, 32'h0);
        repeat (3) @(posedge sys_clk);
        chk(33'h0, {32'h0, irq_out});
        bus(ipr_pkg::OFF_IRQ_MASK, 1'b1, 32'h5);
        rd(ipr_pkg::OFF_IRQ_STAT, 32'h3);
        bus(ipr_pkg::OFF_IRQ_STAT, 1'b1, 32'hf);
        repeat (3) @(posedge sys_clk);
        chk(33'h0, {32'h0, irq_out});
        use_auto <= 1'b1;
        bus(ipr_pkg::OFF_CODES, 1'b1, 32'h0);
        exp_ack.push_back(3'h6);
        req <= 7'h2a;
        ackw();
        rd(ipr_pkg::OFF_VECTOR, 32'hc);
        req <= 7'h0;
        ret();
        bus(ipr_pkg::OFF_CODES, 1'b1, 32'he0);
        exp_ack.push_back(3'h7);
        req <= 7'h40;
        ackw();
        rd(ipr_pkg::OFF_CODES, 32'he0);
        req <= 7'h0;
        repeat (4) @(posedge sys_clk);
        exp_ack.push_back(3'h7);
        req <= 7'h40;
        ackw();
        exp_ack.push_back(3'h7);
        bus(ipr_pkg::OFF_CODES, 1'b1, 32'he0);
        ackw();
        exp_ack.push_back(3'h7);
        bus(ipr_pkg::OFF_RETURN, 1'b1, 32'h1);
        ackw();
        req <= 7'h0;
        ret();
        ret();
        ret();
        bus(ipr_pkg::OFF_ARB, 1'b1, 32'h0);
        req <= 7'h40;
        repeat (20) @(posedge sys_clk);
        exp_ack.push_back(3'h7);
        bus(ipr_pkg::OFF_ARB, 1'b1, 32'hf);
        ackw();
        req <= 7'h0;
        ret();
        // Clock enable low freezes the block, so no acknowledge may open.
        ce <= 1'b0;
        req <= 7'h40;
        repeat (8) @(posedge sys_clk);
        chk(33'h0, {32'h0, ack.active});
        exp_ack.push_back(3'h7);
        ce <= 1'b1;
        ackw();
        req <= 7'h0;
        ret();
        // A second reset with the strap low leaves every pin unassigned.
        strap <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(ipr_pkg::OFF_PIN_ASSIGN, 32'h0);
        req <= 7'h40;
        repeat (8) @(posedge sys_clk);
        summarize();
    end
endmodule : test_interrupt_priority_recognition
